// *** hw/ccs_pkg.sv ***
// Package with constants and types of the counter command and status block.
package ccs_pkg;
  localparam int NCNT = 4;
  localparam int CW   = 32;
  // Command word bit positions.
  localparam int CMD_SNAP_CNT  = 0;
  localparam int CMD_OUT_TO_C  = 1;
  localparam int CMD_GATE_ON   = 2;
  localparam int CMD_LOAD      = 5;
  localparam int CMD_CLR_FLAGS = 6;
  localparam int CMD_SNAP_LAT  = 8;
  localparam int CMD_OUT_FROM_C = 9;
  localparam int CMD_GATE_OFF  = 10;
  localparam logic [15:0] CMD_USED_MASK = 16'h0767;
  // Status word bit positions.
  localparam int ST_CMP  = 9;
  localparam int ST_END  = 10;
  localparam int ST_OFLW = 11;
  localparam int ST_UFLW = 12;
  localparam int ST_ZP   = 13;
  localparam int ST_LACT = 14;
  localparam int ST_NEWL = 15;
  // Record numbers.
  localparam logic [7:0] REC_MODE    = 8'h00;
  localparam logic [7:0] REC_DIAG    = 8'h7F;
  localparam logic [7:0] REC_EDGE    = 8'h80;
  localparam logic [7:0] REC_FILT    = 8'h81;
  localparam logic [7:0] REC_PAR_LO  = 8'h82;
  localparam logic [7:0] REC_PAR_HI  = 8'h99;
  localparam logic [7:0] REC_PRE_LO  = 8'h9A;
  localparam logic [7:0] REC_PRE_HI  = 8'h9D;
  localparam logic [7:0] REC_ANADIG  = 8'h9E;
  localparam logic [7:0] REC_PER_CNT = 8'h06;
  localparam logic [2:0] SIG_OFF     = 3'h0;
  localparam int MEM_AW = 5;
  // Record write from the user program, one 32-bit word at a time.
  typedef struct packed {
    logic        valid;
    logic [7:0]  rec;
    logic [2:0]  word;
    logic [31:0] data;
  } ccs_rec_wr_t;
  // Events from the counting core of one counter.
  typedef struct packed {
    logic          cmp;
    logic          end_hit;
    logic          oflw;
    logic          uflw;
    logic          zero;
    logic          latch_in;
    logic [CW-1:0] count;
    logic [CW-1:0] latch;
  } ccs_evt_t;
endpackage

// *** hw/ccs_param_mem.sv ***
// Small parameter memory holding the per-counter value records.
module ccs_param_mem
  import ccs_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] waddr,
  input  wire logic [31:0]       wdata,
  input  wire logic [MEM_AW-1:0] raddr,
  output logic      [31:0]       rdata
);
  logic [31:0] mem [0:(1<<MEM_AW)-1];
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// *** hw/ccs_top.sv ***
// Command word decoding, status flags and record store for four counters.
// Operation
// - Latch change sets new-latch flag
// - Event flags sticky until clear command
// - Command bits self-clear after action
// - Separate bits switch on and off
// - Bit 0 snapshots count to image
// - Bit 1 gives output to counter
// - Bit 2 sets software gate
// - Bit 5 loads preset record value
// - Bit 6 clears five event flags
// - Bit 8 snapshots latch to image
// - Bit 9 returns output to image
// - Bit 10 clears software gate
// - Mode record: four 32-bit words
// - Mode record refused while running
// - Preset records 9Ah to 9Dh
// - Per-counter value records 82h-99h
// - Accept diagnostic, edge, filter records
// - Accept analogue/digital enable record
// - Latch-active bit mirrors latch input
// - Zero-crossing flag set on zero
// - Signal evaluation 000b deactivates counter
module ccs_top
  import ccs_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 running,
  input  wire logic [NCNT-1:0]      cmd_valid,
  input  wire logic [NCNT*16-1:0]   cmd_word,
  input  wire ccs_rec_wr_t          rec_wr,
  input  wire ccs_evt_t [NCNT-1:0]  evt,
  input  wire logic [NCNT-1:0]      image_do,
  input  wire logic [NCNT-1:0]      core_do,
  output logic                      rec_ack,
  output logic                      rec_refused,
  output logic [NCNT*16-1:0]        status_word,
  output logic [NCNT*CW-1:0]        image_value,
  output logic [NCNT-1:0]           gate_sw,
  output logic [NCNT-1:0]           do_owned,
  output logic [NCNT-1:0]           do_pin,
  output logic [NCNT-1:0]           cnt_active,
  output logic [NCNT-1:0]           load_strobe,
  output logic [NCNT*CW-1:0]        load_value,
  output logic [NCNT*32-1:0]        mode_word,
  output logic [31:0]               diag_cfg,
  output logic [127:0]              edge_cfg,
  output logic [255:0]              filt_cfg,
  output logic [15:0]               anadig_cfg
);
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_READ = 2'b01,
    LD_WAIT = 2'b11
  } ccs_ld_t;

  typedef struct packed {
    logic                  ack;
    logic                  refused;
    logic [NCNT*16-1:0]    status;
    logic [NCNT*CW-1:0]    image;
    logic [NCNT-1:0]       gate;
    logic [NCNT-1:0]       owned;
    logic [NCNT-1:0]       pin;
    logic [NCNT-1:0]       active;
    logic [NCNT-1:0]       strobe;
    logic [NCNT*CW-1:0]    ldval;
    logic [NCNT*32-1:0]    mode;
    logic [31:0]           diag;
    logic [127:0]          edges;
    logic [255:0]          filt;
    logic [15:0]           anadig;
    logic [NCNT*CW-1:0]    last_latch;
    logic [NCNT-1:0]       pend_load;
    ccs_ld_t               ld_st;
    logic [1:0]            ld_idx;
  } ccs_state_t;

  ccs_state_t st_r;
  ccs_state_t st_nxt;

  logic              mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [MEM_AW-1:0] mem_raddr;
  logic [31:0]       mem_rdata;

  // Maps a value or preset record number to a memory address; the word index is not used.
  function automatic logic [MEM_AW-1:0] par_addr(input logic [7:0] rec);
    logic [7:0] d;
    d = rec - REC_PAR_LO;
    par_addr = d[MEM_AW-1:0];
  endfunction

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Preset records sit above the value records in the same memory.
  assign mem_we    = rec_wr.valid && in_range(rec_wr.rec, REC_PAR_LO, REC_PRE_HI)
                     && (rec_wr.word == 3'h0);
  assign mem_waddr = par_addr(rec_wr.rec);
  assign mem_raddr = par_addr(REC_PRE_LO + {6'h00, st_r.ld_idx});

  ccs_param_mem u_mem (
    .core_clk (core_clk),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (rec_wr.data),
    .raddr    (mem_raddr),
    .rdata    (mem_rdata)
  );

  always_comb begin
    logic [15:0] c;
    logic [15:0] s;
    logic        chg;
    logic [2:0]  sig;
    st_nxt = st_r;
    c = 16'h0000;
    s = 16'h0000;
    chg = 1'b0;
    sig = 3'h0;
    st_nxt.ack = 1'b0;
    st_nxt.refused = 1'b0;
    st_nxt.strobe = '0;
    for (int i = 0; i < NCNT; i++) begin
      // Reserved bits are masked; command bits act once per write.
      c = cmd_valid[i] ? (cmd_word[i*16 +: 16] & CMD_USED_MASK) : 16'h0000;
      s = st_r.status[i*16 +: 16];
      sig = st_r.mode[i*32 +: 3];
      st_nxt.active[i] = (sig != SIG_OFF);
      if (c[CMD_CLR_FLAGS]) begin
        s[ST_CMP] = 1'b0;
        s[ST_END] = 1'b0;
        s[ST_OFLW] = 1'b0;
        s[ST_UFLW] = 1'b0;
        s[ST_ZP] = 1'b0;
      end
      if (sig != SIG_OFF) begin
        // Sticky flags, set wins over a simultaneous clear.
        s[ST_CMP]  = s[ST_CMP]  | evt[i].cmp;
        s[ST_END]  = s[ST_END]  | evt[i].end_hit;
        s[ST_OFLW] = s[ST_OFLW] | evt[i].oflw;
        s[ST_UFLW] = s[ST_UFLW] | evt[i].uflw;
        s[ST_ZP]   = s[ST_ZP]   | evt[i].zero;
      end
      s[ST_LACT] = evt[i].latch_in;
      chg = evt[i].latch != st_r.last_latch[i*CW +: CW];
      s[ST_NEWL] = chg;
      st_nxt.last_latch[i*CW +: CW] = evt[i].latch;
      st_nxt.status[i*16 +: 16] = s;
      if (c[CMD_SNAP_CNT]) begin
        st_nxt.image[i*CW +: CW] = evt[i].count;
      end else if (c[CMD_SNAP_LAT]) begin
        st_nxt.image[i*CW +: CW] = evt[i].latch;
      end
      // Separate set and reset bits; zero bits leave state alone.
      if (c[CMD_OUT_TO_C]) begin
        st_nxt.owned[i] = 1'b1;
      end else if (c[CMD_OUT_FROM_C]) begin
        st_nxt.owned[i] = 1'b0;
      end
      if (c[CMD_GATE_ON]) begin
        st_nxt.gate[i] = 1'b1;
      end else if (c[CMD_GATE_OFF]) begin
        st_nxt.gate[i] = 1'b0;
      end
      st_nxt.pin[i] = (st_r.owned[i] && sig != SIG_OFF) ? core_do[i] : image_do[i];
      if (c[CMD_LOAD]) begin
        st_nxt.pend_load[i] = 1'b1;
      end
    end
    // Preset loads are served one counter at a time from the memory.
    case (st_r.ld_st)
      LD_IDLE: begin
        for (int j = NCNT - 1; j >= 0; j--) begin
          if (st_r.pend_load[j]) begin
            st_nxt.ld_idx = 2'(j);
            st_nxt.ld_st = LD_READ;
          end
        end
      end
      LD_READ: begin
        st_nxt.ld_st = LD_WAIT;
      end
      LD_WAIT: begin
        st_nxt.ldval[st_r.ld_idx*CW +: CW] = mem_rdata;
        st_nxt.strobe[st_r.ld_idx] = 1'b1;
        st_nxt.pend_load[st_r.ld_idx] = cmd_valid[st_r.ld_idx]
                                        && cmd_word[st_r.ld_idx*16 + CMD_LOAD];
        st_nxt.ld_st = LD_IDLE;
      end
      default: begin
        st_nxt.ld_st = LD_IDLE;
      end
    endcase
    if (rec_wr.valid) begin
      st_nxt.ack = 1'b1;
      if (rec_wr.rec == REC_MODE) begin
        if (running) begin
          st_nxt.refused = 1'b1;
          st_nxt.ack = 1'b0;
        end else if (rec_wr.word < 3'(NCNT)) begin
          st_nxt.mode[rec_wr.word[1:0]*32 +: 32] = rec_wr.data;
        end
      end else if (rec_wr.rec == REC_DIAG) begin
        st_nxt.diag = rec_wr.data;
      end else if (rec_wr.rec == REC_EDGE) begin
        st_nxt.edges[rec_wr.word[1:0]*32 +: 32] = rec_wr.data;
      end else if (rec_wr.rec == REC_FILT) begin
        st_nxt.filt[rec_wr.word*32 +: 32] = rec_wr.data;
      end else if (rec_wr.rec == REC_ANADIG) begin
        st_nxt.anadig = rec_wr.data[15:0];
      end else if (!in_range(rec_wr.rec, REC_PAR_LO, REC_PRE_HI)) begin
        st_nxt.ack = 1'b0;
        st_nxt.refused = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rec_ack     = st_r.ack;
  assign rec_refused = st_r.refused;
  assign status_word = st_r.status;
  assign image_value = st_r.image;
  assign gate_sw     = st_r.gate;
  assign do_owned    = st_r.owned;
  assign do_pin      = st_r.pin;
  assign cnt_active  = st_r.active;
  assign load_strobe = st_r.strobe;
  assign load_value  = st_r.ldval;
  assign mode_word   = st_r.mode;
  assign diag_cfg    = st_r.diag;
  assign edge_cfg    = st_r.edges;
  assign filt_cfg    = st_r.filt;
  assign anadig_cfg  = st_r.anadig;

  chk_mode_refused: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rec_wr.valid && rec_wr.rec == REC_MODE && running) |=> (rec_refused && $stable(mode_word)))
    else $error("Mode record taken while running.");
  chk_gate_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_GATE_ON]) |=> gate_sw[0])
    else $error("Gate on command not applied.");
  chk_gate_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_GATE_OFF] && !cmd_word[CMD_GATE_ON]) |=> !gate_sw[0])
    else $error("Gate off command not applied.");
  chk_own_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_OUT_TO_C]) |=> do_owned[0])
    else $error("Output not handed to counter.");
  chk_own_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_OUT_FROM_C] && !cmd_word[CMD_OUT_TO_C]) |=> !do_owned[0])
    else $error("Output not taken from counter.");
  chk_zero_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cmd_valid[0]) |=> ($stable(gate_sw[0]) && $stable(do_owned[0])))
    else $error("State changed without command.");
  chk_snap_count: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_SNAP_CNT]) |=> image_value[CW-1:0] == $past(evt[0].count))
    else $error("Count snapshot wrong.");
  chk_clear_flags: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_CLR_FLAGS] && !evt[0].zero) |=> !status_word[ST_ZP])
    else $error("Zero flag not cleared.");
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
    (status_word[ST_OFLW] && !(cmd_valid[0] && cmd_word[CMD_CLR_FLAGS])) |=> status_word[ST_OFLW])
    else $error("Overflow flag dropped.");
  chk_load_once: assert property (@(posedge core_clk) disable iff (sys_rst)
    load_strobe[0] |=> !load_strobe[0])
    else $error("Load strobe longer than one cycle.");
  chk_latch_act: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> status_word[ST_LACT] == $past(evt[0].latch_in))
    else $error("Latch active bit wrong.");
  chk_snap_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_SNAP_LAT] && !cmd_word[CMD_SNAP_CNT])
    |=> image_value[CW-1:0] == $past(evt[0].latch))
    else $error("Latch snapshot wrong.");
  chk_image_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cmd_valid[0]) |=> $stable(image_value[CW-1:0]))
    else $error("Image value changed without command.");
  chk_latch_new: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst)
    |=> status_word[ST_NEWL] == ($past(evt[0].latch) != $past(evt[0].latch, 2)))
    else $error("New latch flag wrong.");
  chk_cmp_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    (evt[0].cmp && mode_word[2:0] != SIG_OFF) |=> status_word[ST_CMP])
    else $error("Compare flag not set.");
  chk_end_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    (evt[0].end_hit && mode_word[2:0] != SIG_OFF) |=> status_word[ST_END])
    else $error("End flag not set.");
  chk_set_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
    (evt[0].oflw && mode_word[2:0] != SIG_OFF) |=> status_word[ST_OFLW])
    else $error("Overflow flag not set.");
  chk_uflw_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    (evt[0].uflw && mode_word[2:0] != SIG_OFF) |=> status_word[ST_UFLW])
    else $error("Underflow flag not set.");
  chk_zero_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    (evt[0].zero && mode_word[2:0] != SIG_OFF) |=> status_word[ST_ZP])
    else $error("Zero crossing flag not set.");
  chk_off_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_word[3*32 +: 3] == SIG_OFF && status_word[3*16+ST_CMP +: 5] == 5'h00)
    |=> status_word[3*16+ST_CMP +: 5] == 5'h00)
    else $error("Deactivated counter raised a flag.");
  chk_active_map: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> cnt_active[0] == ($past(mode_word[2:0]) != SIG_OFF))
    else $error("Active bit does not follow mode.");
  chk_pin_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> do_pin[0] == (($past(do_owned[0]) && $past(mode_word[2:0]) != SIG_OFF)
                           ? $past(core_do[0]) : $past(image_do[0])))
    else $error("Output pin source wrong.");
  chk_load_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_LOAD]) |-> ##[1:9] load_strobe[0])
    else $error("Load command not served.");
  chk_strobe_single: assert property (@(posedge core_clk) disable iff (sys_rst)
    $onehot0(load_strobe))
    else $error("Several load strobes at once.");
  chk_mode_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rec_wr.valid && rec_wr.rec == REC_MODE && !running && rec_wr.word == 3'h0)
    |=> mode_word[31:0] == $past(rec_wr.data))
    else $error("Mode word not stored.");
  chk_mode_taken: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rec_wr.valid && rec_wr.rec == REC_MODE && !running) |=> (rec_ack && !rec_refused))
    else $error("Mode record not accepted while stopped.");
  chk_ack_exclusive: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(rec_ack && rec_refused))
    else $error("Record both accepted and refused.");
  chk_diag_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rec_wr.valid && rec_wr.rec == REC_DIAG) |=> (rec_ack && diag_cfg == $past(rec_wr.data)))
    else $error("Diagnostic record not stored.");
  chk_anadig_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rec_wr.valid && rec_wr.rec == REC_ANADIG) |=> anadig_cfg == $past(rec_wr.data[15:0]))
    else $error("Part enable record not stored.");
  chk_preset_ack: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rec_wr.valid && rec_wr.rec >= REC_PRE_LO && rec_wr.rec <= REC_PRE_HI) |=> rec_ack)
    else $error("Preset record not accepted.");
  chk_value_ack: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rec_wr.valid && rec_wr.rec >= REC_PAR_LO && rec_wr.rec <= REC_PAR_HI) |=> rec_ack)
    else $error("Value record not accepted.");
  chk_reserved_none: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && (cmd_word[15:0] & CMD_USED_MASK) == 16'h0000)
    |=> ($stable(gate_sw[0]) && $stable(do_owned[0]) && $stable(image_value[CW-1:0])))
    else $error("Reserved command bits had an effect.");
  chk_clear_five: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[0] && cmd_word[CMD_CLR_FLAGS]
     && !(evt[0].cmp || evt[0].end_hit || evt[0].oflw || evt[0].uflw || evt[0].zero))
    |=> status_word[ST_ZP:ST_CMP] == 5'h00)
    else $error("Event flags not all cleared.");
  chk_gate_other: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[1] && cmd_word[16 + CMD_GATE_ON]) |=> gate_sw[1])
    else $error("Gate on command not applied to second counter.");
  chk_own_other: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_valid[1] && cmd_word[16 + CMD_OUT_TO_C]) |=> do_owned[1])
    else $error("Output not handed to second counter.");
endmodule

// *** tb/ccs_core_model.sv ***
// Behavioural counting core that answers the command and status block.
module ccs_core_model
  import ccs_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic [NCNT-1:0]    load_strobe,
  input  wire logic [NCNT*CW-1:0] load_value,
  input  wire logic [4:0]         kick,
  input  wire logic               latch_lvl,
  output ccs_evt_t [NCNT-1:0]     evt,
  output logic [NCNT-1:0]         core_do
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt = '0;
  assign core_do = 4'h5;
  always @(posedge core_clk) begin
    for (int i = 0; i < NCNT; i++) begin
      if (load_strobe[i]) evt[i].count <= load_value[i*CW+:CW];
      evt[i].latch_in <= latch_lvl;
      if (latch_lvl && !evt[i].latch_in) evt[i].latch <= evt[i].count;
      {evt[i].cmp, evt[i].end_hit, evt[i].oflw, evt[i].uflw, evt[i].zero}
        <= (i == 0 || i == 3) ? kick : 5'h00;
    end
  end
endmodule

// *** tb/ccs_top_test.sv ***
// Self-checking bench of the counter command and status block.
module ccs_top_test
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] c; logic [15:0] w; logic [3:0] g; logic [3:0] o;} ccs_row_t;
  logic                core_clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                running = 1'b0;
  logic                latch_lvl = 1'b0;
  logic [4:0]          kick = 5'h00;
  logic [NCNT-1:0]     cmd_valid = 4'h0;
  logic [NCNT*16-1:0]  cmd_word = 64'h0;
  ccs_rec_wr_t         rec_wr = '0;
  logic [NCNT-1:0]     image_do = 4'hA;
  ccs_evt_t [NCNT-1:0] evt;
  logic [NCNT-1:0]     core_do, gate_sw, do_owned, do_pin, cnt_active, load_strobe;
  logic                rec_ack, rec_refused;
  logic [NCNT*16-1:0]  status_word;
  logic [NCNT*CW-1:0]  image_value, load_value;
  logic [127:0]        mode_word, edge_cfg;
  logic [31:0]         diag_cfg;
  logic [15:0]         anadig_cfg;
  logic [255:0]        filt_cfg;
  int                  failures = 0;
  int                  checks = 0;
  ccs_row_t rows [8] = '{'{2'h0, 16'h0004, 4'h1, 4'h0}, '{2'h0, 16'h0000, 4'h1, 4'h0},
                         '{2'h0, 16'h0400, 4'h0, 4'h0}, '{2'h0, 16'h0002, 4'h0, 4'h1},
                         '{2'h0, 16'h0200, 4'h0, 4'h0}, '{2'h1, 16'h0006, 4'h2, 4'h2},
                         '{2'h1, 16'h0600, 4'h0, 4'h0}, '{2'h2, 16'h0404, 4'h4, 4'h0}};
  always #4 core_clk = ~core_clk;
  ccs_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .running(running),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .rec_wr(rec_wr), .evt(evt),
    .image_do(image_do), .core_do(core_do), .rec_ack(rec_ack), .rec_refused(rec_refused),
    .status_word(status_word), .image_value(image_value), .gate_sw(gate_sw),
    .do_owned(do_owned), .do_pin(do_pin), .cnt_active(cnt_active),
    .load_strobe(load_strobe), .load_value(load_value), .mode_word(mode_word),
    .diag_cfg(diag_cfg), .edge_cfg(edge_cfg), .filt_cfg(filt_cfg), .anadig_cfg(anadig_cfg));
  ccs_core_model i_core (.core_clk(core_clk), .load_strobe(load_strobe),
    .load_value(load_value), .kick(kick), .latch_lvl(latch_lvl), .evt(evt), .core_do(core_do));
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmd(input int c, input logic [15:0] w);
    @(posedge core_clk);
    cmd_valid[c] <= 1'b1;
    cmd_word[c*16+:16] <= w;
    @(posedge core_clk);
    cmd_valid <= 4'h0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic rec(input logic [7:0] r, input logic [2:0] wd, input logic [31:0] d,
                     input logic ok);
    int k;
    @(posedge core_clk);
    rec_wr <= '{1'b1, r, wd, d};
    @(posedge core_clk);
    rec_wr.valid <= 1'b0;
    k = 0;
    #1;
    while (rec_ack !== 1'b1 && rec_refused !== 1'b1 && k < 4) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk("rec_ack", ok, rec_ack);
    chk("rec_refused", !ok, rec_refused);
  endtask
  task automatic load(input logic [31:0] v);
    int k;
    rec(REC_PRE_LO, 3'h0, v, 1'b1);
    cmd(0, 16'h0020);
    k = 0;
    while (load_strobe[0] !== 1'b1 && k < 6) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk("load_strobe", 1'b1, load_strobe[0]);
    chk("load_value", v, load_value[31:0]);
    repeat (4) begin
      @(posedge core_clk);
      #1;
      chk("load_once", 1'b0, load_strobe[0]);
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset", '0, {rec_ack, gate_sw, do_owned, load_strobe, cnt_active, status_word});
    for (int i = 0; i < 3; i++) rec(REC_MODE, 3'(i), 32'h1, 1'b1);
    rec(REC_MODE, 3'h3, 32'h0, 1'b1);
    chk("cnt_active", 4'h7, cnt_active);
    chk("mode_word", {32'h0, 32'h1, 32'h1, 32'h1}, mode_word);
    @(posedge core_clk);
    running <= 1'b1;
    rec(REC_MODE, 3'h0, 32'h0, 1'b0);
    chk("mode_kept", {32'h0, 32'h1, 32'h1, 32'h1}, mode_word);
    rec(8'h50, 3'h0, 32'h1, 1'b0);
    rec(REC_DIAG, 3'h0, 32'h0000_00A5, 1'b1);
    chk("diag_cfg", 32'h0000_00A5, diag_cfg);
    rec(REC_EDGE, 3'h1, 32'h0000_005A, 1'b1);
    chk("edge_cfg", 32'h0000_005A, edge_cfg[63:32]);
    rec(REC_ANADIG, 3'h0, 32'h0000_0003, 1'b1);
    chk("anadig_cfg", 16'h0003, anadig_cfg);
    rec(REC_FILT, 3'h7, 32'h0000_3C3C, 1'b1);
    chk("filt_cfg", 32'h0000_3C3C, filt_cfg[255:224]);
    rec(8'h88, 3'h0, 32'h0000_0007, 1'b1);
    foreach (rows[i]) begin
      cmd(rows[i].c, rows[i].w);
      chk("gate_sw", rows[i].g, gate_sw);
      chk("do_owned", rows[i].o, do_owned);
      chk("do_pin", (rows[i].o & core_do) | (~rows[i].o & image_do), do_pin);
    end
    load(32'h1234_5678);
    @(posedge core_clk);
    latch_lvl <= 1'b1;
    repeat (6) begin
      @(posedge core_clk);
      #1;
      if (status_word[15] === 1'b1) break;
    end
    chk("latch_new", 1'b1, status_word[15]);
    @(posedge core_clk);
    #1;
    chk("latch_new_end", 1'b0, status_word[15]);
    chk("latch_active", 1'b1, status_word[14]);
    load(32'h0000_00C3);
    cmd(0, 16'h0001);
    chk("image_count", 32'h0000_00C3, image_value[31:0]);
    cmd(0, 16'h0100);
    chk("image_latch", 32'h1234_5678, image_value[31:0]);
    @(posedge core_clk);
    kick <= 5'h1F;
    @(posedge core_clk);
    kick <= 5'h00;
    repeat (3) @(posedge core_clk);
    #1;
    chk("flags", 5'h1F, status_word[13:9]);
    chk("flags_off", 5'h00, status_word[61:57]);
    cmd(0, 16'hF098);
    chk("flags_kept", 5'h1F, status_word[13:9]);
    chk("gate_kept", 4'h4, gate_sw);
    cmd(0, 16'h0040);
    chk("flags_clear", 5'h00, status_word[13:9]);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset_mid", '0, {gate_sw, do_owned, mode_word[31:0], image_value[31:0], status_word[15:0]});
    cmd(0, 16'h0004);
    chk("gate_after_reset", 4'h1, gate_sw);
    tally_and_finish;
  end
  initial begin
    #50000;
    failures++;
    tally_and_finish;
  end
endmodule
